/* rtl/cct_pkg.sv */
`default_nettype none
package cct_pkg;
	// Bus geometry
	localparam int ADDR_W = 26;
	localparam int DATA_W = 16;
	localparam int IDX_W = 8;
	localparam int CARD_AW = 7;
	// Port and register byte addresses, low 16 address bits
	localparam logic [15:0] INDEX_PORT_ADDR = 16'h03E0;
	localparam logic [15:0] DATA_PORT_ADDR = 16'h03E1;
	localparam logic [15:0] CFG_TWO_ADDR = 16'h05FC;
	localparam logic [15:0] CFG_ONE_ADDR = 16'h05FE;
	// Upper address when upper decode is on, and for card I/O windows
	localparam logic [9:0] UPPER_IO_VAL = 10'h100;
	localparam logic [9:0] CARD_IO_UPPER = 10'h100;
	// Slot layout of the index space
	localparam logic [7:0] SLOT_A_BASE = 8'h00;
	localparam logic [7:0] SLOT_B_OFFSET = 8'h40;
	localparam int SLOT_SEL_BIT = 6;
	// Configuration register one fields
	localparam int SLOT_CFG_MSB = 15;
	localparam int SLOT_CFG_LSB = 14;
	localparam int EXT_OR_BIT = 13;
	localparam int DISP_CLK_EN_BIT = 12;
	localparam int SYSBUS_CLK_EN_BIT = 11;
	localparam int UPPER_DEC_BIT = 9;
	localparam int MEMDIV_MSB = 8;
	localparam int MEMDIV_LSB = 6;
	localparam int PIXDIV_MSB = 5;
	localparam int PIXDIV_LSB = 3;
	localparam logic [15:0] CFG_ONE_WMASK = 16'hFBF8;
	localparam logic [15:0] CFG_ONE_RST = 16'h1000;
	// Configuration register two fields
	localparam int REV_MSB = 15;
	localparam int REV_LSB = 12;
	localparam int FB_CLK_SEL_BIT = 10;
	localparam int HOLD_MSB = 3;
	localparam int HOLD_LSB = 2;
	localparam int CHAN_RDY_BIT = 1;
	localparam logic [15:0] CFG_TWO_WMASK = 16'h040E;
	localparam logic [15:0] CFG_TWO_RST = 16'h0000;
	// Arbitrary revision code
	localparam logic [3:0] REVISION_DEFAULT = 4'h5;
endpackage
`default_nettype wire

/* rtl/cct_mem_if.sv */
`default_nettype none
interface cct_mem_if;
	import cct_pkg::*;
	logic we;
	logic [CARD_AW-1:0] addr;
	logic [7:0] wdata;
	logic [7:0] rdata;
	modport ctl (output we, output addr, output wdata, input rdata);
	modport mem (input we, input addr, input wdata, output rdata);
endinterface
`default_nettype wire

/* rtl/cct_card_regfile.sv */
`default_nettype none
module cct_card_regfile #(
	parameter int DEPTH = 128
) (
	input wire logic clk_i,
	input wire logic ce_i,
	cct_mem_if.mem bus
);
	import cct_pkg::*;
	logic [7:0] mem_q [DEPTH];
	logic [7:0] rdata_q;

	// No reset: contents belong to card-controller logic outside this bank
	always_ff @(posedge clk_i) begin
		if (ce_i && bus.we) begin
			mem_q[bus.addr] <= bus.wdata;
		end
	end

	always_ff @(posedge clk_i) begin
		if (ce_i) begin
			rdata_q <= mem_q[bus.addr];
		end
	end

	assign bus.rdata = rdata_q;
endmodule // cct_card_regfile
`default_nettype wire

/* rtl/cct_config_regs.sv */
`default_nettype none
module cct_config_regs #(
	parameter logic [3:0] REVISION = cct_pkg::REVISION_DEFAULT
) (
	input wire logic clk_i,
	input wire logic reset_n_i,
	input wire logic ce_i,
	input wire logic [cct_pkg::ADDR_W-1:0] sa_i,
	input wire logic [cct_pkg::DATA_W-1:0] sd_i,
	input wire logic sbhe_n_i,
	input wire logic iord_n_i,
	input wire logic iowr_n_i,
	output logic [cct_pkg::DATA_W-1:0] sd_o,
	output logic sd_oe_o,
	output logic [1:0] slot_pin_config_o,
	output logic ext_or_en_o,
	output logic display_clocks_en_o,
	output logic internal_sysbus_clock_en_o,
	output logic memclk_tick_o,
	output logic pixclk_tick_o,
	output logic fb_clk_ext_sel_o,
	output logic [1:0] read_hold_ctrl_o,
	output logic chan_ready_drive_mode_o,
	output logic card_slot_b_o,
	output logic card_io_upper_hit_o
);
	import cct_pkg::*;

	function automatic logic addr_hit(input logic [15:0] a, input logic [15:0] target,
			input logic upper_ok);
		addr_hit = upper_ok && (a == target);
	endfunction

	function automatic logic div_reached(input logic [2:0] cnt, input logic [2:0] div);
		div_reached = (cnt == div);
	endfunction

	cct_mem_if mem_bus ();

	logic [15:0] cfg_one_q;
	logic [15:0] cfg_two_q;
	logic [IDX_W-1:0] index_q;
	logic iord_n_q;
	logic iowr_n_q;
	logic rd_start;
	logic wr_start;
	logic upper_ok;
	logic sel_index;
	logic sel_data;
	logic sel_one;
	logic sel_two;
	logic data_rd_pend_q;
	logic index_in_range;
	logic [2:0] mem_cnt_q;
	logic [2:0] pix_cnt_q;
	logic mem_tick;

	// Strobe history; idle bus is high
	always_ff @(posedge clk_i) begin
		if (!reset_n_i) begin
			iord_n_q <= 1'b1;
			iowr_n_q <= 1'b1;
		end else if (ce_i) begin
			iord_n_q <= iord_n_i;
			iowr_n_q <= iowr_n_i;
		end
	end

	assign rd_start = ce_i && !iord_n_i && iord_n_q;
	assign wr_start = ce_i && !iowr_n_i && iowr_n_q;
	assign upper_ok = !cfg_one_q[UPPER_DEC_BIT] || (sa_i[25:16] == UPPER_IO_VAL);
	// Byte ports need the lane that a single byte uses; a word access there is ignored
	assign sel_index = addr_hit(sa_i[15:0], INDEX_PORT_ADDR, upper_ok) && sbhe_n_i;
	assign sel_data = addr_hit(sa_i[15:0], DATA_PORT_ADDR, upper_ok) && !sbhe_n_i;
	// Word registers sit at even addresses and need the high byte enabled
	assign sel_one = addr_hit(sa_i[15:0], CFG_ONE_ADDR, upper_ok) && !sbhe_n_i;
	assign sel_two = addr_hit(sa_i[15:0], CFG_TWO_ADDR, upper_ok) && !sbhe_n_i;
	assign index_in_range = (index_q < (SLOT_B_OFFSET + SLOT_B_OFFSET));

	// Index port
	always_ff @(posedge clk_i) begin
		if (!reset_n_i) begin
			index_q <= SLOT_A_BASE;
		end else if (wr_start && sel_index) begin
			index_q <= sd_i[7:0];
		end
	end

	// Indexed access to the card register array
	assign mem_bus.addr = index_q[CARD_AW-1:0];
	assign mem_bus.we = wr_start && sel_data && index_in_range;
	assign mem_bus.wdata = sd_i[15:8];

	cct_card_regfile #(
		.DEPTH(128)
	) u_regfile (
		.clk_i(clk_i),
		.ce_i(ce_i),
		.bus(mem_bus.mem)
	);

	// Configuration register one; reserved bits never take a one
	always_ff @(posedge clk_i) begin
		if (!reset_n_i) begin
			cfg_one_q <= CFG_ONE_RST;
		end else if (wr_start && sel_one) begin
			cfg_one_q <= sd_i & CFG_ONE_WMASK;
		end
	end

	// Configuration register two; revision nibble is read-only
	always_ff @(posedge clk_i) begin
		if (!reset_n_i) begin
			cfg_two_q <= CFG_TWO_RST;
		end else if (wr_start && sel_two) begin
			cfg_two_q <= sd_i & CFG_TWO_WMASK;
		end
	end

	// Read path; array data lag one cycle behind the strobe edge
	always_ff @(posedge clk_i) begin
		if (!reset_n_i) begin
			sd_o <= 16'h0000;
			sd_oe_o <= 1'b0;
			data_rd_pend_q <= 1'b0;
		end else if (ce_i) begin
			data_rd_pend_q <= rd_start && sel_data;
			if (iord_n_i) begin
				sd_oe_o <= 1'b0;
			end else if (rd_start && (sel_index || sel_data || sel_one || sel_two)) begin
				sd_oe_o <= 1'b1;
			end
			if (rd_start && sel_index) begin
				sd_o <= {8'h00, index_q};
			end else if (rd_start && sel_one) begin
				sd_o <= cfg_one_q;
			end else if (rd_start && sel_two) begin
				sd_o <= {REVISION, cfg_two_q[11:0]};
			end else if (data_rd_pend_q) begin
				sd_o <= index_in_range ? {mem_bus.rdata, 8'h00} : 16'h0000;
			end
		end
	end

	// Display clock dividers as enable pulses on the master clock
	assign mem_tick = div_reached(mem_cnt_q, cfg_one_q[MEMDIV_MSB:MEMDIV_LSB]);

	always_ff @(posedge clk_i) begin
		if (!reset_n_i) begin
			mem_cnt_q <= 3'h0;
			memclk_tick_o <= 1'b0;
		end else if (ce_i) begin
			memclk_tick_o <= cfg_one_q[DISP_CLK_EN_BIT] && mem_tick;
			if (!cfg_one_q[DISP_CLK_EN_BIT] || mem_tick) begin
				mem_cnt_q <= 3'h0;
			end else begin
				mem_cnt_q <= mem_cnt_q + 3'h1;
			end
		end
	end

	// Pixel divider counts memory-clock pulses, not master clocks
	always_ff @(posedge clk_i) begin
		if (!reset_n_i) begin
			pix_cnt_q <= 3'h0;
			pixclk_tick_o <= 1'b0;
		end else if (ce_i) begin
			pixclk_tick_o <= 1'b0;
			if (!cfg_one_q[DISP_CLK_EN_BIT]) begin
				pix_cnt_q <= 3'h0;
			end else if (mem_tick) begin
				if (div_reached(pix_cnt_q, cfg_one_q[PIXDIV_MSB:PIXDIV_LSB])) begin
					pix_cnt_q <= 3'h0;
					pixclk_tick_o <= 1'b1;
				end else begin
					pix_cnt_q <= pix_cnt_q + 3'h1;
				end
			end
		end
	end

	// Control outputs, one flop each so glitches never reach the pins
	always_ff @(posedge clk_i) begin
		if (!reset_n_i) begin
			slot_pin_config_o <= 2'b00;
			ext_or_en_o <= 1'b0;
			display_clocks_en_o <= 1'b1;
			internal_sysbus_clock_en_o <= 1'b0;
			fb_clk_ext_sel_o <= 1'b0;
			read_hold_ctrl_o <= 2'b00;
			chan_ready_drive_mode_o <= 1'b0;
			card_slot_b_o <= 1'b0;
			card_io_upper_hit_o <= 1'b0;
		end else if (ce_i) begin
			slot_pin_config_o <= cfg_one_q[SLOT_CFG_MSB:SLOT_CFG_LSB];
			ext_or_en_o <= cfg_one_q[EXT_OR_BIT];
			display_clocks_en_o <= cfg_one_q[DISP_CLK_EN_BIT];
			internal_sysbus_clock_en_o <= cfg_one_q[SYSBUS_CLK_EN_BIT];
			fb_clk_ext_sel_o <= cfg_two_q[FB_CLK_SEL_BIT];
			read_hold_ctrl_o <= cfg_two_q[HOLD_MSB:HOLD_LSB];
			chan_ready_drive_mode_o <= cfg_two_q[CHAN_RDY_BIT];
			card_slot_b_o <= index_q[SLOT_SEL_BIT];
			// Card windows ignore the upper decode bit entirely
			card_io_upper_hit_o <= (sa_i[25:16] == CARD_IO_UPPER);
		end
	end

	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!reset_n_i);

	sequence s_index_write;
		wr_start && sel_index;
	endsequence

	sequence s_slot_seen;
		##2 (card_slot_b_o == $past(sd_i[SLOT_SEL_BIT], 2));
	endsequence

	property p_index_write;
		s_index_write |=> (index_q == $past(sd_i[7:0]));
	endproperty
	a_index_write: assert property (p_index_write) else $error("index not stored");

	property p_index_word_ignored;
		(wr_start && !sbhe_n_i && (sa_i[15:0] == INDEX_PORT_ADDR)) |=> $stable(index_q);
	endproperty
	a_index_word_ignored: assert property (p_index_word_ignored)
		else $error("word write changed index");

	property p_data_read;
		(rd_start && sel_data && index_in_range) ##1 (ce_i && !iord_n_i)
			##1 (ce_i && !iord_n_i)
			|-> (sd_oe_o && sd_o == {$past(mem_bus.rdata), 8'h00});
	endproperty
	a_data_read: assert property (p_data_read) else $error("data port read lane wrong");

	property p_slot_sel;
		(s_index_write ##1 ce_i [*2]) |-> (card_slot_b_o == $past(index_q[SLOT_SEL_BIT]));
	endproperty
	a_slot_sel: assert property (p_slot_sel) else $error("slot select wrong");

	property p_cfg_byte_ignored;
		(wr_start && sbhe_n_i && (sa_i[15:0] == CFG_ONE_ADDR)) |=> $stable(cfg_one_q);
	endproperty
	a_cfg_byte_ignored: assert property (p_cfg_byte_ignored)
		else $error("byte write changed config");

	property p_reserved_zero;
		((cfg_one_q & ~CFG_ONE_WMASK) == 16'h0000) && ((cfg_two_q & ~CFG_TWO_WMASK) == 16'h0000);
	endproperty
	a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bit set");

	property p_reset_value;
		disable iff (1'b0) !reset_n_i |=> (cfg_one_q == CFG_ONE_RST && cfg_two_q == CFG_TWO_RST);
	endproperty
	a_reset_value: assert property (p_reset_value) else $error("reset value wrong");

	property p_upper_decode;
		(wr_start && cfg_one_q[UPPER_DEC_BIT] && (sa_i[25:16] != UPPER_IO_VAL)) |=>
			($stable(cfg_one_q) && $stable(cfg_two_q) && $stable(index_q));
	endproperty
	a_upper_decode: assert property (p_upper_decode) else $error("upper decode ignored");

	property p_mem_div;
		(ce_i && cfg_one_q[DISP_CLK_EN_BIT] && mem_tick) |=> (memclk_tick_o && mem_cnt_q == 3'h0);
	endproperty
	a_mem_div: assert property (p_mem_div) else $error("memory clock divider wrong");

	property p_pix_tick_aligned;
		(ce_i && $past(ce_i) && pixclk_tick_o) |-> $past(mem_tick);
	endproperty
	a_pix_tick_aligned: assert property (p_pix_tick_aligned)
		else $error("pixel pulse off memory pulse");
endmodule // cct_config_regs
`default_nettype wire

/* verification/cct_host_model.sv */
`default_nettype none
module cct_host_model (
	input wire logic clk_i,
	input wire logic [15:0] rd_i,
	input wire logic rd_oe_i,
	output logic [25:0] sa_o,
	output logic [15:0] sd_o,
	output logic sbhe_n_o,
	output logic iord_n_o,
	output logic iowr_n_o
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		sa_o = 26'h0000000;
		sd_o = 16'hFFFF;
		sbhe_n_o = 1'b1;
		iord_n_o = 1'b1;
		iowr_n_o = 1'b1;
	end
	// No ready line: strobe held three edges, data valid by the third
	task automatic io(input logic wr, input logic [25:0] a, input logic [15:0] d,
		input logic bhe_n, output logic [15:0] q, output logic oe);
		@(posedge clk_i);
		#1;
		sa_o = a;
		sbhe_n_o = bhe_n;
		sd_o = d;
		iowr_n_o = !wr;
		iord_n_o = wr;
		repeat (3) @(posedge clk_i);
		#1;
		q = rd_i;
		oe = rd_oe_i;
		iowr_n_o = 1'b1;
		iord_n_o = 1'b1;
		// Released bus never shows the last value
		sd_o = ~d;
	endtask
endmodule // cct_host_model
`default_nettype wire

/* verification/testbench.sv */
`default_nettype none
module testbench;
	import cct_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [25:0] AI = {10'h000, INDEX_PORT_ADDR};
	localparam logic [25:0] AD = {10'h000, DATA_PORT_ADDR};
	localparam logic [25:0] A1 = {10'h000, CFG_ONE_ADDR};
	localparam logic [25:0] A2 = {10'h000, CFG_TWO_ADDR};
	logic clk_i, reset_n_i, ce_i, sbhe_n_i, iord_n_i, iowr_n_i, sd_oe_o, oe;
	logic [25:0] sa_i;
	logic [15:0] sd_i, sd_o, q;
	logic [1:0] slot_pin_config_o, read_hold_ctrl_o;
	logic ext_or_en_o, display_clocks_en_o, internal_sysbus_clock_en_o, memclk_tick_o;
	logic pixclk_tick_o, fb_clk_ext_sel_o, chan_ready_drive_mode_o, card_slot_b_o;
	logic card_io_upper_hit_o;
	int error_cnt, checks_done, cyc;
	cct_config_regs dut (.clk_i, .reset_n_i, .ce_i, .sa_i, .sd_i, .sbhe_n_i, .iord_n_i,
		.iowr_n_i, .sd_o, .sd_oe_o, .slot_pin_config_o, .ext_or_en_o, .display_clocks_en_o,
		.internal_sysbus_clock_en_o, .memclk_tick_o, .pixclk_tick_o, .fb_clk_ext_sel_o,
		.read_hold_ctrl_o, .chan_ready_drive_mode_o, .card_slot_b_o, .card_io_upper_hit_o);
	cct_host_model host (.clk_i(clk_i), .rd_i(sd_o), .rd_oe_i(sd_oe_o), .sa_o(sa_i),
		.sd_o(sd_i), .sbhe_n_o(sbhe_n_i), .iord_n_o(iord_n_i), .iowr_n_o(iowr_n_i));
	task automatic report_and_stop();
		$display("checks %0d errors %0d", checks_done, error_cnt);
		if (error_cnt == 0 && checks_done > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		checks_done++;
		if (got !== exp) begin
			error_cnt++;
			$display("ERROR t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [25:0] a, input logic [15:0] d, input logic b);
		host.io(1'b1, a, d, b, q, oe);
	endtask
	task automatic rdc(input logic [25:0] a, input logic b, input logic [15:0] e, input logic eo);
		host.io(1'b0, a, 16'h0000, b, q, oe);
		chk({15'h0000, oe}, {15'h0000, eo});
		if (eo)
			chk(q, e);
	endtask
	function automatic logic [15:0] f_two(input logic [15:0] d);
		return {REVISION_DEFAULT, d[11:0] & CFG_TWO_WMASK[11:0]};
	endfunction
	task automatic gaps(output int gm, output int gp);
		int tm[$];
		int tp[$];
		for (int i = 0; i < 400; i++) begin
			@(posedge clk_i);
			#1;
			if (memclk_tick_o === 1'b1)
				tm.push_back(i);
			if (pixclk_tick_o === 1'b1)
				tp.push_back(i);
		end
		if (tm.size() < 3 || tp.size() < 3) begin
			gm = -1;
			gp = -1;
		end else begin
			gm = tm[2] - tm[1];
			gp = tp[2] - tp[1];
		end
	endtask
	initial begin
		clk_i = 1'b0;
		forever #10 clk_i = ~clk_i;
	end
	initial begin
		cyc = 0;
		forever begin
			@(posedge clk_i);
			cyc++;
			if (cyc == 5000) begin
				error_cnt++;
				report_and_stop();
			end
		end
	end
	initial begin
		logic [15:0] v;
		logic [7:0] ix, b1, b2;
		logic [2:0] m, p;
		int gm, gp;
		error_cnt = 0;
		checks_done = 0;
		reset_n_i = 1'b0;
		ce_i = 1'b1;
		void'($urandom(8));
		repeat (16) @(posedge clk_i);
		#1;
		reset_n_i = 1'b1;
		rdc(A1, 1'b0, CFG_ONE_RST, 1'b1);
		rdc(A2, 1'b0, {REVISION_DEFAULT, 12'h000}, 1'b1);
		chk({14'h0000, display_clocks_en_o, internal_sysbus_clock_en_o}, 16'h0002);
		wr(A1, 16'h0000, 1'b1);
		rdc(A1, 1'b0, CFG_ONE_RST, 1'b1);
		rdc({10'h000, 16'h05FA}, 1'b0, 16'h0000, 1'b0);
		for (int n = 0; n < 4; n++) begin
			// Host keeps reserved bits and upper decode at zero
			v = (16'($urandom) & CFG_ONE_WMASK & 16'h3DFF) | (16'(n) << 14);
			wr(A1, v, 1'b0);
			rdc(A1, 1'b0, v, 1'b1);
			chk({11'h000, slot_pin_config_o, ext_or_en_o, display_clocks_en_o,
				internal_sysbus_clock_en_o}, {11'h000, v[15:11]});
			v = (16'($urandom) & 16'h0402) | (16'(n) << 2);
			wr(A2, v, 1'b0);
			rdc(A2, 1'b0, f_two(v), 1'b1);
			chk({12'h000, fb_clk_ext_sel_o, read_hold_ctrl_o, chan_ready_drive_mode_o},
				{12'h000, v[10], v[3:2], v[1]});
		end
		for (int n = 0; n < 6; n++) begin
			ix = (n == 0) ? 8'h3F : 8'($urandom % 64);
			b1 = 8'($urandom);
			b2 = ~b1;
			wr(AI, {8'hA5, ix}, 1'b1);
			wr(AD, {b1, 8'h00}, 1'b0);
			wr(AI, {8'h5A, ix | SLOT_B_OFFSET}, 1'b1);
			chk({15'h0000, card_slot_b_o}, 16'h0001);
			wr(AD, {b2, 8'h00}, 1'b0);
			wr(AI, {8'h00, ix}, 1'b0);
			rdc(AI, 1'b1, {8'h00, ix | SLOT_B_OFFSET}, 1'b1);
			rdc(AD, 1'b1, 16'h0000, 1'b0);
			rdc(AD, 1'b0, {b2, 8'h00}, 1'b1);
			wr(AI, {8'h00, ix}, 1'b1);
			chk({15'h0000, card_slot_b_o}, 16'h0000);
			rdc(AD, 1'b0, {b1, 8'h00}, 1'b1);
		end
		wr(AI, {8'h00, 8'h80 | ix}, 1'b1);
		wr(AD, {b2, 8'h00}, 1'b0);
		rdc(AD, 1'b0, 16'h0000, 1'b1);
		wr(AI, {8'h00, ix}, 1'b1);
		rdc(AD, 1'b0, {b1, 8'h00}, 1'b1);
		wr(A1, 16'h1200, 1'b0);
		rdc(A1, 1'b0, 16'h0000, 1'b0);
		rdc({10'h200, CFG_ONE_ADDR}, 1'b0, 16'h0000, 1'b0);
		// Wrong upper address must not land while upper decode is on
		wr(A1, 16'h0000, 1'b0);
		rdc({10'h100, CFG_ONE_ADDR}, 1'b0, 16'h1200, 1'b1);
		chk({15'h0000, card_io_upper_hit_o}, 16'h0001);
		rdc({10'h100, INDEX_PORT_ADDR}, 1'b1, {8'h00, ix}, 1'b1);
		wr({10'h100, CFG_ONE_ADDR}, 16'h1000, 1'b0);
		rdc({10'h3FF, CFG_ONE_ADDR}, 1'b0, 16'h1000, 1'b1);
		chk({15'h0000, card_io_upper_hit_o}, 16'h0000);
		for (int n = 0; n < 3; n++) begin
			m = (n == 0) ? 3'h0 : (n == 1) ? 3'h7 : 3'($urandom);
			p = (n == 0) ? 3'h0 : (n == 1) ? 3'h7 : 3'($urandom);
			v = 16'h1000 | (16'(m) << 6) | (16'(p) << 3);
			wr(A1, v, 1'b0);
			gaps(gm, gp);
			chk(16'(gm), 16'(m) + 16'h0001);
			chk(16'(gp), (16'(m) + 16'h0001) * (16'(p) + 16'h0001));
		end
		// Enable low: a whole write strobe goes unseen
		ce_i = 1'b0;
		wr(A1, 16'h2000, 1'b0);
		ce_i = 1'b1;
		rdc(A1, 1'b0, v, 1'b1);
		report_and_stop();
	end
endmodule // testbench
`default_nettype wire
